// ==== rtl/kcl_pkg.sv ====
// constants, types and behaviour summary for the keypad combination lock
// Behaviour
// R1: four stored combinations, up to sixteen hex characters, one picked by two-bit select.
// R2: the select switches choose the combination for every compare and unlock.
// R3: a combination may be shorter; its own terminal count sets entry length.
// R4: keypad pulls its reset line low while the reset key is held.
// R5: keypad reset is buffered into an internal active-low reset for lock state.
// R6: internal reset forces pass true, actuation timer off, character counter zero.
// R7: keypad shows hex code on four data lines with active-low strobe.
// R8: keypad strobe is buffered into an internal active-low strobe.
// R9: while strobe low, compare input with stored character at counter and selection.
// R10: match is high when input equals addressed character, low otherwise.
// R11: on strobe rising edge, load match into pass flop and advance counter.
// R12: a latched mismatch holds pass false and clears the counter.
// R13: while pass is false, comparisons are ignored and no unlock occurs.
// R14: counter advances per good match and stops at the terminal count.
// R15: unlock only at terminal count, strobe low and final character matching.
// R16: a falling unlock starts a 10 second timer that drives the actuator high.
// R17: alarm output when the entry holds more characters than allowed.
// R18: strobe and reset are synchronised and the strobe rise is a single pulse.
// R19: actuation interval counts clock cycles; a new unlock restarts it.
`default_nettype none
package kcl_pkg;

   // ***************************************
   // clock and timing
   // ***************************************
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned ACT_TIME_S  = 10;                  // actuation time in seconds
   localparam int unsigned ACT_CYCLES  = ACT_TIME_S * CLK_HZ; // 250e6 fits 32 bits
   localparam int unsigned TIMER_W     = 28;

   // ***************************************
   // register map (word addresses)
   // ***************************************
   localparam int unsigned ADDR_W      = 7;
   localparam logic [6:0]  REG_STATE   = 7'h00;
   localparam logic [6:0]  REG_IRQ_ST  = 7'h01;
   localparam logic [6:0]  REG_IRQ_MSK = 7'h02;
   localparam logic [6:0]  REG_TERM0   = 7'h04;  // 7'h04..7'h07, one per combination
   localparam logic [6:0]  REG_CHAR0   = 7'h40;  // 7'h40..7'h7F, {combo, index}
   localparam logic [3:0]  TERM_RESET  = 4'hF;
   localparam logic [3:0]  CHAR_RESET  = 4'h0;

   // interrupt bit positions
   localparam int unsigned IRQ_UNLOCK  = 0;
   localparam int unsigned IRQ_FAIL    = 1;
   localparam int unsigned IRQ_ALARM   = 2;
   localparam int unsigned IRQ_W       = 3;

   // ***************************************
   // types
   // ***************************************
   typedef struct packed {
      logic [3:0] data;
      logic       strobe_n;
      logic       reset_n;
      logic       combo_switch_hi;
      logic       combo_switch_lo;
   } kcl_keypad_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0]       wdata;
      logic              wr;
      logic              rd;
   } kcl_bus_req_t;

endpackage
`default_nettype wire

// ==== rtl/kcl_lock.sv ====
// keypad combination lock: synchroniser, compare logic, timer, registers
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`default_nettype none

// ***************************************
// signal flow
// ***************************************
// keypad pins -> three-stage synchroniser -> agreement filter
// filtered strobe low: live compare, unlock may fire
// filtered strobe rise: one-cycle event, steps pass and counter
// unlock fall: loads the actuation timer
// register port: table, terminal counts, status, interrupts
//
// register map, word addresses
// 00      state, read only
//         [3:0] char count, [4] pass, [5] actuator
//         [6] alarm, [7] entry completed
//         [9:8] combination select, [13:10] its terminal count
// 01      interrupt status, write one to clear
//         [0] unlock, [1] mismatch, [2] overlong entry
// 02      interrupt mask, same layout
// 04..07  terminal count per combination, index of last character
// 40..7F  character table, address [5:4] combination, [3:0] position
// irq: high while any unmasked status bit is set
//
// limitations
// strobe pulses under two clocks may be lost in the filter
// table writes during an entry change what the next key compares with
// repeating the final key does not retrigger: completion blocks unlock

module kcl_lock #(
   parameter int unsigned ACT_CYCLES = kcl_pkg::ACT_CYCLES
) (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire kcl_pkg::kcl_keypad_t keypad,
   input  wire kcl_pkg::kcl_bus_req_t bus,
   output logic [31:0]               rd_data,
   output logic                      actuator,
   output logic                      alarm,
   output logic                      irq
);
   import kcl_pkg::*;

   localparam int unsigned SYN_W = $bits(kcl_keypad_t);
   localparam logic [TIMER_W-1:0] ACT_LOAD = TIMER_W'(ACT_CYCLES);

   // ***************************************
   // pin synchroniser
   // ***************************************
   logic [SYN_W-1:0] sync1, sync2, sync3, pin_filt;
   kcl_keypad_t      kp;

   // three stages; a bit moves only once stages two and three agree
   always_ff @(posedge clk) begin
      if (reset) begin
         sync1    <= '1;
         sync2    <= '1;
         sync3    <= '1;
         pin_filt <= '1;
      end else begin
         sync1    <= keypad;
         sync2    <= sync1;
         sync3    <= sync2;
         pin_filt <= (~(sync2 ^ sync3) & sync3) | ((sync2 ^ sync3) & pin_filt); // [R18]
      end
   end
   assign kp = pin_filt;

   // stage views, read only by the filter check
   kcl_keypad_t      stage2, stage3;
   assign stage2 = sync2;
   assign stage3 = sync3;

   logic       buffered_reset_n, buffered_strobe_n, strobe_prev, strobe_rise;
   logic [1:0] combo_select;
   logic       lock_reset;

   assign buffered_reset_n  = kp.reset_n;                        // [R5]
   assign buffered_strobe_n = kp.strobe_n;                       // [R8]
   assign combo_select      = {kp.combo_switch_hi, kp.combo_switch_lo}; // [R2]
   assign lock_reset        = reset | ~buffered_reset_n;

   // strobe edge, in the first cycle the filtered level is high
   always_ff @(posedge clk) begin
      if (reset) begin
         strobe_prev <= 1'b1;
      end else begin
         strobe_prev <= buffered_strobe_n;
      end
   end
   assign strobe_rise = buffered_strobe_n & ~strobe_prev;        // [R18]

   // ***************************************
   // combination store and compare
   // ***************************************
   logic [3:0] combo_mem [0:63];
   logic [3:0] term_count [0:3];
   logic [3:0] char_count;
   logic [3:0] sel_term;
   logic       char_match;
   logic       pass;
   logic       completed;
   logic       wr_char, wr_term;

   assign wr_char = bus.wr && bus.addr[6];
   assign wr_term = bus.wr && (bus.addr[6:2] == REG_TERM0[6:2]);

   // stored characters, written by software
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < 64; i++) begin
            combo_mem[i] <= CHAR_RESET;
         end
      end else if (wr_char) begin
         combo_mem[bus.addr[5:0]] <= bus.wdata[3:0];             // [R1]
      end
   end

   // terminal count per combination: index of its last character
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < 4; i++) begin
            term_count[i] <= TERM_RESET;
         end
      end else if (wr_term) begin
         term_count[bus.addr[1:0]] <= bus.wdata[3:0];            // [R3]
      end
   end

   assign sel_term   = term_count[combo_select];                 // [R3]
   // compare against the character at {selection, count}
   assign char_match = (kp.data == combo_mem[{combo_select, char_count}]); // [R9] [R10]

   // ***************************************
   // pass flop, counter, overflow
   // ***************************************
   logic fail_evt, alarm_evt;

   assign fail_evt  = strobe_rise && pass && !completed && !char_match && !lock_reset;
   assign alarm_evt = strobe_rise && pass && completed && !lock_reset;

   always_ff @(posedge clk) begin
      if (lock_reset) begin
         pass       <= 1'b1;                                     // [R6]
         char_count <= 4'h0;                                     // [R6]
         completed  <= 1'b0;
      end else if (strobe_rise && pass) begin
         if (completed) begin
            pass       <= 1'b0;   // extra character spoils the entry
            char_count <= 4'h0;
         end else if (!char_match) begin
            pass       <= 1'b0;                                  // [R11] [R12]
            char_count <= 4'h0;                                  // [R12]
         end else if (char_count != sel_term) begin
            char_count <= char_count + 4'h1;                     // [R11] [R14]
         end else begin
            completed  <= 1'b1;                                  // [R14]
         end
      end
      // pass low: strobes are ignored until the next reset [R13]
   end

   // alarm holds until the keypad reset
   always_ff @(posedge clk) begin
      if (lock_reset) begin
         alarm <= 1'b0;
      end else if (alarm_evt) begin
         alarm <= 1'b1;                                          // [R17]
      end
   end

   // ***************************************
   // unlock and actuation timer
   // ***************************************
   logic               unlock_n, unlock_prev_n, unlock_fall;
   logic [TIMER_W-1:0] timer;

   assign unlock_n = ~(pass && !completed && (char_count == sel_term)
                       && !buffered_strobe_n && char_match);     // [R15] [R13]

   always_ff @(posedge clk) begin
      if (lock_reset) begin
         unlock_prev_n <= 1'b1;
      end else begin
         unlock_prev_n <= unlock_n;
      end
   end
   assign unlock_fall = unlock_prev_n & ~unlock_n;               // [R16]

   // counts down; a new unlock reloads the full interval
   always_ff @(posedge clk) begin
      if (lock_reset) begin
         timer    <= '0;                                         // [R6]
         actuator <= 1'b0;                                       // [R6]
      end else if (unlock_fall) begin
         timer    <= ACT_LOAD;                                   // [R16] [R19]
         actuator <= 1'b1;                                       // [R16]
      end else if (timer != '0) begin
         timer    <= timer - TIMER_W'(1);                        // [R19]
         actuator <= (timer != TIMER_W'(1));
      end
   end

   // checker helper: cycles of the current actuation run
   logic [TIMER_W-1:0] act_run;

   always_ff @(posedge clk) begin
      if (lock_reset || unlock_fall) begin
         act_run <= '0;
      end else if (actuator) begin
         act_run <= act_run + TIMER_W'(1);
      end
   end

   // ***************************************
   // interrupts and register reads
   // ***************************************
   logic [IRQ_W-1:0] irq_status, irq_mask, irq_set, irq_clr;

   assign irq_set = {alarm_evt, fail_evt, unlock_fall & ~lock_reset};
   assign irq_clr = (bus.wr && bus.addr == REG_IRQ_ST) ? bus.wdata[IRQ_W-1:0] : '0;

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_status <= '0;
      end else begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq_mask <= '0;
      end else if (bus.wr && bus.addr == REG_IRQ_MSK) begin
         irq_mask <= bus.wdata[IRQ_W-1:0];
      end
   end

   assign irq = |(irq_status & irq_mask);

   // read data valid the cycle after the strobe only
   always_ff @(posedge clk) begin
      if (reset || !bus.rd) begin
         rd_data <= 32'h0000_0000;
      end else if (bus.addr[6]) begin
         rd_data <= {28'h0000000, combo_mem[bus.addr[5:0]]};
      end else if (bus.addr[6:2] == REG_TERM0[6:2]) begin
         rd_data <= {28'h0000000, term_count[bus.addr[1:0]]};
      end else if (bus.addr == REG_STATE) begin
         rd_data <= {18'h00000, sel_term, combo_select, completed, alarm,
                     actuator, pass, char_count};
      end else if (bus.addr == REG_IRQ_ST) begin
         rd_data <= {29'h00000000, irq_status};
      end else if (bus.addr == REG_IRQ_MSK) begin
         rd_data <= {29'h00000000, irq_mask};
      end else begin
         rd_data <= 32'h0000_0000;
      end
   end

   // ***************************************
   // checks
   // ***************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_reset_state: assert property (lock_reset |=> pass && char_count == 4'h0 && !actuator) // [R6]
      else $error("lock reset did not clear state");
   a_fail_latch: assert property (fail_evt |=> !pass && char_count == 4'h0) // [R12]
      else $error("mismatch not latched");
   a_fail_holds: assert property (!pass && !lock_reset |=> !pass) // [R13]
      else $error("pass recovered without reset");
   a_count_step: assert property (strobe_rise && pass && !completed && char_match // [R11]
                                  && char_count != sel_term && !lock_reset
                                  |=> char_count == $past(char_count) + 4'h1)
      else $error("counter did not advance");
   a_count_stops: assert property (strobe_rise && pass && !completed && char_match // [R14]
                                   && char_count == sel_term && !lock_reset
                                   |=> char_count == $past(char_count) && completed)
      else $error("counter passed terminal count");
   // final key checked against the table at the terminal index, not the counter
   a_unlock_cause: assert property (!unlock_n |-> pass && !completed && !buffered_strobe_n // [R15]
                                    && char_count == sel_term
                                    && kp.data == combo_mem[{combo_select, sel_term}])
      else $error("unlock without all conditions");
   a_timer_start: assert property (unlock_fall && !lock_reset |=> actuator && timer == ACT_LOAD) // [R16]
      else $error("timer not started by unlock");
   a_timer_end: assert property (actuator && timer == TIMER_W'(1) && !unlock_fall // [R19]
                                 && !lock_reset |=> !actuator && timer == '0)
      else $error("actuation did not end on count");
   a_alarm_set: assert property (alarm_evt |=> alarm && !pass) // [R17]
      else $error("overlong entry raised no alarm");
   a_strobe_pulse: assert property (strobe_rise |=> !strobe_rise) // [R18]
      else $error("strobe edge longer than one cycle");

   // ***************************************
   // further checks
   // ***************************************
   // the filtered strobe may only move when stages two and three agreed
   a_filter_agree: assert property ($changed(buffered_strobe_n) // [R18]
                                    |-> $past(stage2.strobe_n) == $past(stage3.strobe_n)
                                    && buffered_strobe_n == $past(stage3.strobe_n))
      else $error("strobe filter moved without agreement");

   // edge event only on a low-to-high step of the filtered strobe
   a_strobe_edge: assert property (strobe_rise |-> buffered_strobe_n && !$past(buffered_strobe_n)) // [R18]
      else $error("strobe event without a rising step");

   // pass and counter move only on a strobe event or a lock reset
   a_quiet_state: assert property (!strobe_rise && !lock_reset // [R11]
                                   |=> $stable(pass) && $stable(char_count) && $stable(completed))
      else $error("lock state moved without a strobe");

   // a failed entry always rests at count zero
   a_fail_count: assert property (!pass |-> char_count == 4'h0) // [R12]
      else $error("count not cleared after mismatch");

   // no actuation can start while the entry is spoilt
   a_failed_shut: assert property (!pass && !lock_reset |=> !unlock_fall) // [R13]
      else $error("unlock after a mismatch");

   // completion holds until the next lock reset
   a_done_holds: assert property (completed && !lock_reset |=> completed) // [R14]
      else $error("completion lost without reset");

   // alarm stays up until the keypad reset
   a_alarm_holds: assert property (alarm && !lock_reset |=> alarm) // [R17]
      else $error("alarm dropped without reset");

   // alarm rises only on a strobe after a completed entry
   a_alarm_cause: assert property ($rose(alarm) |-> $past(completed) && $past(strobe_rise)) // [R17]
      else $error("alarm without an overlong entry");

   // a lock reset also clears the alarm and the completion mark
   a_rekey_clear: assert property (lock_reset |=> !alarm && !completed) // [R6]
      else $error("lock reset left alarm or completion");

   // the actuator is high exactly while the timer runs
   a_timer_tracks: assert property (actuator == (timer != '0)) // [R16]
      else $error("actuator and timer disagree");

   // a run never outlasts the programmed interval
   a_act_bound: assert property (act_run <= ACT_LOAD) // [R19]
      else $error("actuation longer than the interval");

   // a run that ends on its own lasted the full interval
   a_act_length: assert property ($fell(actuator) && !$past(lock_reset) |-> act_run == ACT_LOAD) // [R16]
      else $error("actuation shorter than the interval");

   // each lock event leaves its sticky flag set, whatever was written
   a_open_flag: assert property (unlock_fall && !lock_reset |=> irq_status[IRQ_UNLOCK])
      else $error("unlock flag not set");
   a_fail_flag: assert property (fail_evt |=> irq_status[IRQ_FAIL])
      else $error("mismatch flag not set");
   a_alarm_flag: assert property (alarm_evt |=> irq_status[IRQ_ALARM])
      else $error("alarm flag not set");

   // status moves only on an event or a clearing write
   a_flag_quiet: assert property (irq_set == '0 && !(bus.wr && bus.addr == REG_IRQ_ST)
                                  |=> $stable(irq_status))
      else $error("status changed without cause");

   // read data shows only in the cycle after a read strobe
   a_rd_quiet: assert property (!bus.rd |=> rd_data == 32'h0000_0000)
      else $error("read data outside its cycle");

   // main scenarios reached
   c_unlock:  cover property (unlock_fall ##1 actuator);
   c_fail:    cover property (fail_evt);
   c_alarm:   cover property (alarm_evt);
   c_expire:  cover property ($fell(actuator) && !lock_reset);
   c_rekey:   cover property (lock_reset && !reset);

endmodule
`default_nettype wire

// ==== rtl/kcl_unused_placeholder.sv ====
// intentionally empty design unit list
`default_nettype none
`default_nettype wire

// ==== tb/kcl_keypad_model.sv ====
// behavioural hex keypad with strobe and reset keys
`default_nettype none
module kcl_keypad_model (
   input  wire logic                 clk,
   input  wire logic [1:0]           sel,
   output var  kcl_pkg::kcl_keypad_t keypad
);
   timeunit 1ns;
   timeprecision 1ns;
   import kcl_pkg::*;

   logic [3:0] d   = 4'h0;
   logic       s_n = 1'b1;
   logic       r_n = 1'b1;

   // switches pass straight through; keys come from the tasks
   always_comb keypad = {d, s_n, r_n, sel};

   // one key; code settles before the strobe falls and outlives its rise
   task automatic press(input logic [3:0] c, input int low);
      @(posedge clk) d <= c;
      repeat (2) @(posedge clk);
      s_n <= 1'b0;
      repeat (low) @(posedge clk);
      s_n <= 1'b1;
      repeat (3) @(posedge clk);
      d <= ~c; // released lines show garbage, never the old code
      repeat (5) @(posedge clk);
   endtask

   // reset key held long enough to pass the input filter
   task automatic reset_key();
      @(posedge clk) r_n <= 1'b0;
      repeat (8) @(posedge clk);
      r_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ==== tb/test_keypad_combination_lock.sv ====
// self-checking bench for the keypad combination lock
`default_nettype none
module test_keypad_combination_lock;
   timeunit 1ns;
   timeprecision 1ns;
   import kcl_pkg::*;

   localparam int          ACT     = 20;  // short actuation keeps the run brief
   localparam logic [31:0] ST_MASK = 32'h0000_3FFF;
   logic         clk   = 1'b0;
   logic         reset = 1'b1;
   logic [1:0]   sel   = 2'h0;
   logic [1:0]   s;
   kcl_keypad_t  keypad;
   kcl_bus_req_t bus   = '0;
   logic [31:0]  rd_data;
   logic         actuator;
   logic         alarm;
   logic         irq;
   logic         act_q = 1'b0;
   logic [31:0]  rnd   = 32'h0001_2F37;
   logic [3:0]   code [16];
   logic [3:0]   term;
   int           err_count = 0;
   int           checks = 0;
   int           run = 0;
   int           last_run = 0;
   int           opens = 0;
   int           n0;

   kcl_lock #(.ACT_CYCLES(ACT)) uut (.clk(clk), .reset(reset), .keypad(keypad), .bus(bus),
      .rd_data(rd_data), .actuator(actuator), .alarm(alarm), .irq(irq));
   kcl_keypad_model km (.clk(clk), .sel(sel), .keypad(keypad));

   // 25 MHz clock
   always #20 clk = ~clk;

   // length of each actuation run and number of its starts
   always @(posedge clk) begin
      if (actuator) run++;
      else if (run != 0) begin
         last_run = run;
         run = 0;
      end
      if (actuator && !act_q) opens++;
      act_q = actuator;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   // expected status word for the chosen combination
   function automatic logic [31:0] state_exp(input logic [3:0] cnt, input logic pass);
      return {18'h0, term, s, 3'h0, pass, cnt};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk) bus <= '0;
   endtask

   // data is taken at the edge closing the cycle after the strobe
   task automatic rd_chk(input string what, input logic [6:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] v;
      @(posedge clk) bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk) bus <= '0;
      @(posedge clk) v = rd_data;
      check(what, v & m, e);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard, far beyond the expected run of under two thousand cycles
   initial begin
      repeat (40000) @(posedge clk);
      err_count++;
      wrap_up();
   end

   // main sequence: full, single and random length combinations
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      check("rd_idle", rd_data, 32'h0);
      rd_chk("term_rst", REG_TERM0, 32'hF, 32'(TERM_RESET));
      rd_chk("char_rst", REG_CHAR0, 32'hF, 32'(CHAR_RESET));
      rd_chk("unmapped", 7'h03, 32'hFFFF_FFFF, 32'h0);
      for (int k = 0; k < 3; k++) begin
         rnd = lfsr(rnd);
         s = rnd[1:0];
         sel <= s;
         term = (k == 0) ? 4'hF : (k == 1) ? 4'h0 : rnd[5:2];
         wr(REG_TERM0 + {5'h0, s}, {28'h0, term});
         for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            code[i] = (rnd[3:0] == 4'h0) ? 4'hA : rnd[3:0];
            wr(REG_CHAR0 | {1'b0, s, 4'(i)}, {28'h0, code[i]});
         end
         km.reset_key();
         wr(REG_IRQ_ST, 32'h7);
         rd_chk("start", REG_STATE, ST_MASK, state_exp(4'h0, 1'b1));
         n0 = opens;
         for (int i = 0; i <= int'(term); i++) begin
            km.press(code[i], 5 + i % 4);
            if (i < int'(term)) rd_chk("count", REG_STATE, ST_MASK, state_exp(4'(i + 1), 1'b1));
         end
         check("opens", 32'(opens - n0), 32'h1);
         repeat (ACT + 10) @(posedge clk);
         check("run", 32'(last_run), 32'(ACT));
         rd_chk("irq_open", REG_IRQ_ST, 32'h7, 32'h1);
         km.press(code[0], 5);
         check("alarm", 32'(alarm), 32'h1);
         rd_chk("irq_alarm", REG_IRQ_ST, 32'h5, 32'h5);
         check("irq_masked", 32'(irq), 32'h0);
         wr(REG_IRQ_MSK, 32'h4);
         @(posedge clk) check("irq_on", 32'(irq), 32'h1);
         wr(REG_IRQ_ST, 32'h7);
         @(posedge clk) check("irq_off", 32'(irq), 32'h0);
         wr(REG_IRQ_MSK, 32'h0);
         // wrong first key, then the right string must stay refused
         km.reset_key();
         rd_chk("rekey", REG_STATE, ST_MASK, state_exp(4'h0, 1'b1));
         n0 = opens;
         km.press(code[0] ^ 4'h8, 6);
         rd_chk("fail", REG_STATE, ST_MASK, state_exp(4'h0, 1'b0));
         for (int i = 0; i <= int'(term); i++) km.press(code[i], 6);
         check("no_open", 32'(opens - n0), 32'h0);
         rd_chk("irq_fail", REG_IRQ_ST, 32'h2, 32'h2);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
